// file: hw/physical_address_router.sv
// Physical address router: I/O ranges and memory ceilings select dram or mmio.
`timescale 1ns/1ps

// Notes on behaviour
// - Range hit: write bit picks dram or mmio.
// - Range hit: read bit picks dram or mmio.
// - Base field bits 51:12, low bits zero.
// - Mask valid bit 11 enables the pair.
// - Mask field bits 51:12, variable-range style.
// - Exactly two ranges, each base/mask pair.
// - All range fields read and write.
// - Range overlap with type uses combination table.
// - Low ceiling splits below 4 GB.
// - High ceiling splits above 4 GB.
// - Ceiling overlap with type uses combination table.
// - Ceilings hold bits 51:23, others ignored.
// - Config bit 20 enables low ceiling.
// - Config bit 21 enables high ceiling.
// - Disabled ceilings default to mmio.
// - Fewer address bits narrow the fields.
// - Type codes 0,1,4,5,6 are UC,WC,WT,WP,WB.
module physical_address_router #(
    parameter int PA_BITS = 52
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Model-specific register port.
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [2:0] reg_index,
    input wire logic [63:0] reg_wdata,
    output logic [63:0] reg_rdata,
    output logic reg_ack,
    output logic reg_fault,
    // Access request from the load/store path.
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic [PA_BITS-1:0] acc_addr,
    input wire logic [2:0] acc_type,
    // Routing answer.
    output logic route_valid,
    output logic route_to_dram,
    output logic [2:0] route_type,
    output logic route_reserved
);
    import router_pkg::*;

    localparam int FW = PA_BITS - RANGE_LSB;
    localparam int CW = PA_BITS - CEIL_LSB;

    ////////////////////////////////////////////////////////////////////////
    logic [FW-1:0] base_field [2];
    logic [FW-1:0] mask_field [2];
    logic [1:0] write_to_dram;
    logic [1:0] read_from_dram;
    logic [1:0] range_valid;
    logic [CW-1:0] low_ceil;
    logic [CW-1:0] high_ceil;
    logic low_ceiling_enable;
    logic high_ceiling_enable;

    // Membership as in the variable-range type registers.
    function automatic logic range_hit(input logic [FW-1:0] a,
                                       input logic [FW-1:0] b,
                                       input logic [FW-1:0] m);
        range_hit = (a & m) == (b & m);
    endfunction

    // Only the listed cells of the combination table are defined.
    function automatic logic combo_reserved(input logic rd, input logic wr,
                                            input logic [2:0] t);
        logic known;
        known = (t == MT_UC) || (t == MT_WC) || (t == MT_WT) ||
                (t == MT_WP) || (t == MT_WB);
        case ({rd, wr})
            2'b00: combo_reserved = !known || t == MT_WB;
            2'b01: combo_reserved = t != MT_UC;
            2'b10: combo_reserved = !(t == MT_UC || t == MT_WP);
            2'b11: combo_reserved = !known || t == MT_WP;
            default: combo_reserved = 1'b1;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register port decode.
    function automatic logic write_at(input logic strobe,
                                      input logic [2:0] idx,
                                      input logic [2:0] want);
        write_at = strobe && idx == want;
    endfunction

    wire logic [FW-1:0] wr_field = reg_wdata[PA_BITS-1:RANGE_LSB];
    wire logic [CW-1:0] wr_ceil = reg_wdata[PA_BITS-1:CEIL_LSB];
    wire logic index_ok = reg_index <= IDX_SYSTEM_CONFIGURATION_REGISTER;
    wire logic sel_base0 = write_at(reg_write, reg_index, IDX_IO_BASE0);
    wire logic sel_base1 = write_at(reg_write, reg_index, IDX_IO_BASE1);
    wire logic sel_mask0 = write_at(reg_write, reg_index, IDX_IO_MASK0);
    wire logic sel_mask1 = write_at(reg_write, reg_index, IDX_IO_MASK1);
    wire logic sel_low = write_at(reg_write, reg_index, IDX_LOW_CEIL);
    wire logic sel_high = write_at(reg_write, reg_index, IDX_HIGH_CEIL);
    wire logic sel_config = write_at(reg_write, reg_index, IDX_SYSTEM_CONFIGURATION_REGISTER);
    wire logic [1:0] sel_base = {sel_base1, sel_base0};
    wire logic [1:0] sel_mask = {sel_mask1, sel_mask0};

    // Base registers of both ranges.
    always_ff @(posedge clk)
    begin
        for (int n = 0; n < 2; n++)
        begin
            if (!resetn)
            begin
                base_field[n] <= '0;
                write_to_dram[n] <= 1'b0;
                read_from_dram[n] <= 1'b0;
            end
            else if (sel_base[n])
            begin
                base_field[n] <= wr_field;
                write_to_dram[n] <= reg_wdata[WR_DRAM_BIT];
                read_from_dram[n] <= reg_wdata[RD_DRAM_BIT];
            end
        end
    end

    // Mask registers of both ranges; a pair stays off until validated.
    always_ff @(posedge clk)
    begin
        for (int n = 0; n < 2; n++)
        begin
            if (!resetn)
            begin
                mask_field[n] <= '0;
                range_valid[n] <= 1'b0;
            end
            else if (sel_mask[n])
            begin
                mask_field[n] <= wr_field;
                range_valid[n] <= reg_wdata[VALID_BIT];
            end
        end
    end

    // Ceilings keep only their aligned bits, so reserved bits cost nothing.
    always_ff @(posedge clk)
    begin
        if (!resetn)
            low_ceil <= '0;
        else if (sel_low)
            low_ceil <= wr_ceil;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            high_ceil <= '0;
        else if (sel_high)
            high_ceil <= wr_ceil;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            low_ceiling_enable <= 1'b0;
            high_ceiling_enable <= 1'b0;
        end
        else if (sel_config)
        begin
            low_ceiling_enable <= reg_wdata[LOW_EN_BIT];
            high_ceiling_enable <= reg_wdata[HIGH_EN_BIT];
        end
    end

    // Read images; fields outside those held read as zero.
    function automatic logic [63:0] base_image(input logic [FW-1:0] f,
                                               input logic wr,
                                               input logic rd);
        base_image = REG_RESET;
        base_image[PA_BITS-1:RANGE_LSB] = f;
        base_image[WR_DRAM_BIT] = wr;
        base_image[RD_DRAM_BIT] = rd;
    endfunction

    function automatic logic [63:0] mask_image(input logic [FW-1:0] f,
                                               input logic v);
        mask_image = REG_RESET;
        mask_image[PA_BITS-1:RANGE_LSB] = f;
        mask_image[VALID_BIT] = v;
    endfunction

    function automatic logic [63:0] ceil_image(input logic [CW-1:0] c);
        ceil_image = REG_RESET;
        ceil_image[PA_BITS-1:CEIL_LSB] = c;
    endfunction

    wire logic [63:0] image_base0 =
        base_image(base_field[0], write_to_dram[0], read_from_dram[0]);
    wire logic [63:0] image_base1 =
        base_image(base_field[1], write_to_dram[1], read_from_dram[1]);
    wire logic [63:0] image_mask0 =
        mask_image(mask_field[0], range_valid[0]);
    wire logic [63:0] image_mask1 =
        mask_image(mask_field[1], range_valid[1]);
    wire logic [63:0] image_low = ceil_image(low_ceil);
    wire logic [63:0] image_high = ceil_image(high_ceil);
    logic [63:0] image_config;
    always_comb
    begin
        image_config = REG_RESET;
        image_config[LOW_EN_BIT] = low_ceiling_enable;
        image_config[HIGH_EN_BIT] = high_ceiling_enable;
    end

    logic [63:0] rd_view;
    always_comb
    begin
        case (reg_index)
            IDX_IO_BASE0: rd_view = image_base0;
            IDX_IO_BASE1: rd_view = image_base1;
            IDX_IO_MASK0: rd_view = image_mask0;
            IDX_IO_MASK1: rd_view = image_mask1;
            IDX_LOW_CEIL: rd_view = image_low;
            IDX_HIGH_CEIL: rd_view = image_high;
            IDX_SYSTEM_CONFIGURATION_REGISTER: rd_view = image_config;
            default: rd_view = REG_RESET;
        endcase
    end

    wire logic reg_strobe = reg_read || reg_write;
    wire logic read_ok = reg_read && index_ok;
    // Idle and unmapped cycles return zero so a stale word never leaks.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            reg_rdata <= REG_RESET;
            reg_ack <= 1'b0;
            reg_fault <= 1'b0;
        end
        else
        begin
            reg_rdata <= read_ok ? rd_view : REG_RESET;
            reg_ack <= reg_strobe;
            reg_fault <= reg_strobe && !index_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Routing decision.
    wire logic [FW-1:0] addr_field = acc_addr[PA_BITS-1:RANGE_LSB];
    wire logic [CW-1:0] addr_ceil = acc_addr[PA_BITS-1:CEIL_LSB];
    wire logic above_4g = |acc_addr[PA_BITS-1:FOUR_GB_BIT];
    wire logic hit0 = range_valid[0] &&
        range_hit(addr_field, base_field[0], mask_field[0]);
    wire logic hit1 = range_valid[1] &&
        range_hit(addr_field, base_field[1], mask_field[1]);
    // Ceilings are compared in whole 8-Mbyte blocks.
    function automatic logic below_ceiling(input logic [CW-1:0] a,
                                           input logic [CW-1:0] c);
        below_ceiling = a < c;
    endfunction

    wire logic any_hit = hit0 || hit1;
    // Overlapping ranges are unspecified; range 0 simply takes precedence.
    wire logic hit_rd = hit0 ? read_from_dram[0] : read_from_dram[1];
    wire logic hit_wr = hit0 ? write_to_dram[0] : write_to_dram[1];
    wire logic low_dram = low_ceiling_enable && !above_4g &&
        below_ceiling(addr_ceil, low_ceil);
    wire logic high_dram = high_ceiling_enable && above_4g &&
        below_ceiling(addr_ceil, high_ceil);
    wire logic ceil_dram = low_dram || high_dram;
    // A range hit overrides the ceilings for the whole access.
    wire logic eff_rd = any_hit ? hit_rd : ceil_dram;
    wire logic eff_wr = any_hit ? hit_wr : ceil_dram;
    wire logic next_to_dram = acc_write ? eff_wr : eff_rd;
    wire logic next_reserved = combo_reserved(eff_rd, eff_wr,
                                              acc_type);

    // The access is forwarded as seen; the decision rides beside it.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            route_valid <= 1'b0;
            route_type <= MT_UC;
        end
        else
        begin
            route_valid <= acc_valid;
            route_type <= acc_type;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            route_to_dram <= 1'b0;
            route_reserved <= 1'b0;
        end
        else
        begin
            route_to_dram <= next_to_dram;
            route_reserved <= next_reserved;
        end
    end
endmodule

// file: shared/router_pkg.sv
// Constants for the physical address router: register indices and fields.
package router_pkg;
    // Register indices on the model-specific register port.
    localparam logic [2:0] IDX_IO_BASE0 = 3'h0;
    localparam logic [2:0] IDX_IO_MASK0 = 3'h1;
    localparam logic [2:0] IDX_IO_BASE1 = 3'h2;
    localparam logic [2:0] IDX_IO_MASK1 = 3'h3;
    localparam logic [2:0] IDX_LOW_CEIL = 3'h4;
    localparam logic [2:0] IDX_HIGH_CEIL = 3'h5;
    localparam logic [2:0] IDX_SYSTEM_CONFIGURATION_REGISTER = 3'h6;
    // Field positions.
    localparam int WR_DRAM_BIT = 3;
    localparam int RD_DRAM_BIT = 4;
    localparam int VALID_BIT = 11;
    localparam int RANGE_LSB = 12;
    localparam int CEIL_LSB = 23;
    localparam int PA_MAX = 52;
    localparam int LOW_EN_BIT = 20;
    localparam int HIGH_EN_BIT = 21;
    localparam int FOUR_GB_BIT = 32;
    // Reset values.
    localparam logic [63:0] REG_RESET = 64'h0000_0000_0000_0000;
    // Memory type encodings.
    localparam logic [2:0] MT_UC = 3'h0;
    localparam logic [2:0] MT_WC = 3'h1;
    localparam logic [2:0] MT_WT = 3'h4;
    localparam logic [2:0] MT_WP = 3'h5;
    localparam logic [2:0] MT_WB = 3'h6;
endpackage

// file: testbench/router_checker.sv
// Checker of the router's register and routing ports.
`timescale 1ns/1ps
module router_checker (
    // Clock, reset and register port.
    input wire logic clk,
    input wire logic resetn,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [2:0] reg_index,
    input wire logic [63:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic reg_fault,
    // Access and routing.
    input wire logic acc_valid,
    input wire logic [2:0] acc_type,
    input wire logic route_valid,
    input wire logic route_to_dram,
    input wire logic [2:0] route_type,
    input wire logic route_reserved
);
    logic wrote;
    logic strobe;
    assign strobe = reg_write | reg_read;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // Until the first write every range and ceiling is off.
    always_ff @(posedge clk)
        wrote <= resetn & (wrote | reg_write);
    ////////////////////////////////////////////////////////////
    AST_ACK: assert property (strobe |=> reg_ack)
        else $error("ack missing");
    AST_NO_ACK: assert property (!strobe |=> !reg_ack && !reg_fault)
        else $error("stray ack");
    AST_FAULT: assert property (reg_index == 3'h7 && strobe |=> reg_fault)
        else $error("fault missing");
    AST_IDLE_DATA: assert property (!reg_read |=> reg_rdata == 64'h0)
        else $error("read data not cleared");
    AST_FORWARD: assert property ($past(resetn) |->
        route_valid == $past(acc_valid) && route_type == $past(acc_type))
        else $error("access not forwarded");
    AST_OFF_MMIO: assert property (!wrote && acc_valid |=> !route_to_dram)
        else $error("dram while ceilings off");
    AST_OFF_WB: assert property (!wrote && acc_valid &&
        acc_type == 3'h6 |=> route_reserved) else $error("WB not reserved");
    AST_OFF_UC: assert property (!wrote && acc_valid &&
        acc_type == 3'h0 |=> !route_reserved) else $error("UC reserved");
    cover property (reg_ack && reg_fault);
    cover property (route_valid && route_to_dram);
    cover property (route_valid && route_reserved);
endmodule
////////////////////////////////////////////////////////////
bind physical_address_router router_checker i_router_checker (.clk, .resetn,
    .reg_write, .reg_read, .reg_index, .reg_rdata, .reg_ack, .reg_fault,
    .acc_valid, .acc_type, .route_valid, .route_to_dram, .route_type,
    .route_reserved);

// file: testbench/access_source.sv
// Load/store path model that feeds accesses to the router.
`timescale 1ns/1ps
module access_source (
    // Clock and commands from the bench.
    input wire logic clk,
    input wire logic req,
    input wire logic wr,
    input wire logic [51:0] addr,
    input wire logic [2:0] typ,
    // Access lines toward the router.
    output logic acc_valid = 1'b0,
    output logic acc_write = 1'b0,
    output logic [51:0] acc_addr = 52'h0,
    output logic [2:0] acc_type = 3'h0
);
    // Idle cycles drop acc_valid and invert the other lines, so a stale value never looks valid.
    always @(posedge clk)
    begin
        acc_valid <= req;
        acc_write <= req ? wr : ~acc_write;
        acc_addr <= req ? addr : ~acc_addr;
        acc_type <= req ? typ : ~acc_type;
    end
endmodule

// file: testbench/physical_address_router_tb_top.sv
// Self-checking bench for the physical address router.
`timescale 1ns/1ps
module physical_address_router_tb_top;
    import router_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic req = 1'b0, wr = 1'b0, reg_ack, reg_fault, acc_valid, acc_write;
    logic route_valid, route_to_dram, route_reserved;
    logic [2:0] reg_index = 3'h0, typ = 3'h0, acc_type, route_type;
    logic [63:0] reg_wdata = 64'h0, reg_rdata;
    logic [51:0] addr = 52'h0, acc_addr;
    int failures = 0, total_checks = 0, cycles = 0;
    always #50 clk = ~clk;
    access_source i_access_source (.clk, .req, .wr, .addr, .typ, .acc_valid,
        .acc_write, .acc_addr, .acc_type);
    physical_address_router i_physical_address_router (.clk, .resetn,
        .reg_write, .reg_read, .reg_index, .reg_wdata, .reg_rdata, .reg_ack,
        .reg_fault, .acc_valid, .acc_write, .acc_addr, .acc_type,
        .route_valid, .route_to_dram, .route_type, .route_reserved);
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [2:0] i, input logic [63:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_index <= i;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic reg_rd(input logic [2:0] i, input logic [63:0] d);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_index <= i;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 check(reg_rdata, d);
        check({62'h0, reg_ack, reg_fault}, {62'h0, 1'b1, i == 3'h7});
    endtask
    // Expected result e is {to dram, reserved}.
    task automatic acc(input logic w, input logic [51:0] a,
        input logic [2:0] t, input logic [1:0] e);
        @(posedge clk);
        req <= 1'b1;
        wr <= w;
        addr <= a;
        typ <= t;
        @(posedge clk);
        req <= 1'b0;
        @(posedge clk);
        #1 check({58'h0, route_valid, route_to_dram, route_reserved,
            route_type}, {58'h0, 1'b1, e, t});
    endtask
    ////////////////////////////////////////////////////////////
    task automatic s_reset_state();
        acc(1'b0, 52'h1000, MT_UC, 2'h0);
        acc(1'b1, 52'h100000000, MT_WB, 2'h1);
        reg_rd(IDX_IO_MASK0, 64'h0);
        reg_rd(3'h7, 64'h0);
    endtask
    task automatic s_ceilings();
        reg_wr(IDX_LOW_CEIL, 64'hFFF0000080400FFF);
        reg_rd(IDX_LOW_CEIL, 64'h80000000);
        reg_wr(IDX_HIGH_CEIL, 64'h200000000);
        acc(1'b0, 52'h7FFFFFFF, MT_UC, 2'h0);
        reg_wr(IDX_SYSTEM_CONFIGURATION_REGISTER, 64'h300000);
        acc(1'b0, 52'h7FFFFFFF, MT_WB, 2'h2);
        acc(1'b1, 52'h80000000, MT_UC, 2'h0);
        acc(1'b0, 52'h1FFFFFFFF, MT_WT, 2'h2);
        acc(1'b1, 52'h200000000, MT_UC, 2'h0);
        acc(1'b0, 52'h2000, 3'h2, 2'h3);
        acc(1'b1, 52'h7FFFF000, MT_WP, 2'h3);
        reg_wr(IDX_SYSTEM_CONFIGURATION_REGISTER, 64'h100000);
        acc(1'b0, 52'h100000000, MT_UC, 2'h0);
        reg_rd(IDX_SYSTEM_CONFIGURATION_REGISTER, 64'h100000);
    endtask
    task automatic s_ranges();
        reg_wr(IDX_IO_BASE0, 64'hFFF0000000100FE8);
        reg_rd(IDX_IO_BASE0, 64'h100008);
        reg_wr(IDX_IO_MASK0, 64'hFFFFFFFF00000);
        acc(1'b0, 52'h100000, MT_UC, 2'h2);
        reg_wr(IDX_IO_MASK0, 64'hFFFFFFFFFFF00FFF);
        reg_rd(IDX_IO_MASK0, 64'hFFFFFFFF00800);
        acc(1'b0, 52'h100000, MT_UC, 2'h0);
        acc(1'b1, 52'h1FFFFF, MT_UC, 2'h2);
        acc(1'b0, 52'h100000, MT_WC, 2'h1);
        acc(1'b0, 52'h200000, MT_UC, 2'h2);
        reg_wr(IDX_IO_BASE1, 64'h90000010);
        reg_wr(IDX_IO_MASK1, 64'hFFFFFFFF00800);
        acc(1'b0, 52'h90000000, MT_WP, 2'h2);
        acc(1'b1, 52'h900FF000, MT_WB, 2'h1);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            failures++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        s_reset_state();
        s_ceilings();
        s_ranges();
        print_verdict();
    end
endmodule
